// ===== src/adh_pkg.sv
/*
  Shared constants and types for the six-channel converter host port.
  Assumes one 100 MHz system clock; the conversion clock is a sampled pin.
*/
package adh_pkg;
  localparam int unsigned ADH_CHANNELS = 6;
  localparam int unsigned ADH_PAIRS = 3;
  localparam int unsigned ADH_DATA_W = 16;
  localparam int unsigned ADH_CTRL_W = 8;
  // Conversion length in conversion-clock cycles.
  localparam logic [4:0] ADH_CONV_CYCLES = 5'h10;
  // Result latch point, in conversion-clock half cycles (16.5 cycles).
  localparam int unsigned ADH_LATCH_HALF_CYCLES = 33;
  // Control word layout.
  localparam int unsigned ADH_CW_CFG = 7;
  localparam int unsigned ADH_CW_LIGHT = 6;
  localparam int unsigned ADH_CW_DEEP = 5;
  localparam int unsigned ADH_CW_INV = 4;
  localparam int unsigned ADH_CW_TAG = 3;
  localparam int unsigned ADH_CW_RST = 3;
  localparam logic [6:0] ADH_CFG_RESET = 7'h00;
  localparam logic [3:0] ADH_TRIG_RESET = 4'hF;
  // Read selector codes.
  localparam logic [2:0] ADH_SEL_CYCLE = 3'h6;
  localparam logic [2:0] ADH_SEL_FIFO = 3'h7;
  // Fixed prefix of the 16-bit channel tag word.
  localparam logic [11:0] ADH_TAG_PREFIX = 12'h800;
  localparam logic [2:0] ADH_PTR_LAST = 3'h5;
  localparam logic [2:0] ADH_FIFO_FULL = 3'h6;

  typedef enum logic [1:0] {
    ADH_IDLE = 2'h0,
    ADH_ARMED = 2'h1,
    ADH_CONV = 2'h3,
    ADH_LATCH = 2'h2
  } adh_pair_state_t;
endpackage

// ===== src/adh_pair_seq.sv
/*
  Sequencer for one channel pair: hold edge, conversion count, latch request.
  Assumes conv_rise and conv_fall are one-cycle event pulses from the parent.
*/
`timescale 1ns/10ps
`default_nettype none
module adh_pair_seq (
  input wire logic clk,
  input wire logic dev_rst,
  input wire logic conv_rise,
  input wire logic conv_fall,
  input wire logic sample_n,
  output logic track,
  output logic latch_req
);
  adh_pkg::adh_pair_state_t state;
  logic sample_q;
  logic [4:0] count;

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      sample_q <= sample_n;
    end else begin
      sample_q <= sample_n;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      state <= adh_pkg::ADH_IDLE;
      count <= 5'h00;
      latch_req <= 1'b0;
    end else begin
      latch_req <= 1'b0;
      case (state)
        adh_pkg::ADH_IDLE: begin
          if (sample_q && !sample_n) begin
            state <= adh_pkg::ADH_ARMED;
          end
        end
        adh_pkg::ADH_ARMED: begin
          if (conv_rise) begin
            state <= adh_pkg::ADH_CONV;
            count <= 5'h00;
          end
        end
        adh_pkg::ADH_CONV: begin
          if (conv_rise) begin
            if (count == adh_pkg::ADH_CONV_CYCLES - 5'h01) begin
              state <= adh_pkg::ADH_LATCH;
            end else begin
              count <= count + 5'h01;
            end
          end
        end
        adh_pkg::ADH_LATCH: begin
          if (conv_fall) begin
            latch_req <= 1'b1;
            state <= adh_pkg::ADH_IDLE;
          end
        end
        default: begin
          state <= adh_pkg::ADH_IDLE;
        end
      endcase
    end
  end

  assign track = (state == adh_pkg::ADH_IDLE) || (state == adh_pkg::ADH_LATCH);
endmodule // adh_pair_seq
`default_nettype wire

// ===== src/adh_host_port.sv
/*
  Digital front end of a six-channel simultaneous-sampling converter: hold
  strobes, result latching, parallel read port and control word.
  Assumes all pins are synchronous to clk and conv_clk is at most clk/4.
*/
`timescale 1ns/10ps
`default_nettype none
module adh_host_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_clk,
  input wire logic reset_pin_n,
  input wire logic pair_a_sample_n,
  input wire logic pair_b_sample_n,
  input wire logic pair_c_sample_n,
  input wire logic read_sel0,
  input wire logic read_sel1,
  input wire logic read_sel2,
  input wire logic light_sleep_pin,
  input wire logic tag_enable_pin,
  input wire logic byte_mode,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] data_pins_in,
  input wire logic [15:0] conv_result [6],
  output logic [15:0] data_pins_out,
  output logic data_pins_oe,
  output logic eoc_n,
  output logic first_channel_next,
  output logic [2:0] pair_track,
  output logic light_sleep,
  output logic deep_sleep
);
  logic [6:0] control_cfg;
  logic [3:0] control_trig;
  logic dev_rst, conv_q, conv_rise, conv_fall, wr_q, rd_q, rd_act, rd_start, rd_end, rd_busy;
  logic late, do_latch, latch_due, seq_mode, tag_on, chan_done;
  logic [2:0] pair_sample_n, seq_track, seq_latch, pending, want, sel_now, sel_q, cyc_ptr;
  logic [2:0] fifo_cnt, next_fifo_cnt;
  logic [1:0] latch_pair, phase, last_phase;
  logic [5:0] result_valid;
  logic [15:0] next_data;
  logic [15:0] result [6], fifo_data [6], next_fifo_data [6];
  logic [2:0] fifo_addr [6], next_fifo_addr [6];

  function automatic logic is_seq(input logic [2:0] sel);
    is_seq = (sel == adh_pkg::ADH_SEL_CYCLE) || (sel == adh_pkg::ADH_SEL_FIFO);
  endfunction
  function automatic logic [15:0] both_lanes(input logic [7:0] b);
    both_lanes = {b, b};
  endfunction

  assign dev_rst = sys_rst || !(reset_pin_n && control_trig[adh_pkg::ADH_CW_RST]);
  assign pair_sample_n[0] = pair_a_sample_n && control_trig[2];
  assign pair_sample_n[1] = pair_b_sample_n && control_trig[1];
  assign pair_sample_n[2] = pair_c_sample_n && control_trig[0];
  assign sel_now = {read_sel2, read_sel1, read_sel0} | control_cfg[2:0];
  assign tag_on = tag_enable_pin || control_cfg[adh_pkg::ADH_CW_TAG];

  assign conv_rise = conv_clk && !conv_q;
  assign conv_fall = !conv_clk && conv_q;
  assign rd_act = !cs_n && !rd_n;
  assign rd_start = rd_act && !rd_q;
  assign rd_end = !rd_act && rd_q;
  assign rd_busy = rd_act || rd_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      conv_q <= conv_clk;
      wr_q <= !cs_n && !wr_n;
      rd_q <= rd_act;
    end
  end

  // Strobe bits ignore dev_rst, so a written reset bit clears itself after one cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_trig <= adh_pkg::ADH_TRIG_RESET;
    end else if (!wr_q && !cs_n && !wr_n && !data_pins_in[adh_pkg::ADH_CW_CFG]) begin
      control_trig <= data_pins_in[3:0];
    end else if (!control_trig[adh_pkg::ADH_CW_RST]) begin
      control_trig <= adh_pkg::ADH_TRIG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      control_cfg <= adh_pkg::ADH_CFG_RESET;
    end else if (!wr_q && !cs_n && !wr_n && data_pins_in[adh_pkg::ADH_CW_CFG]) begin
      control_cfg <= data_pins_in[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      light_sleep <= 1'b0;
      deep_sleep <= 1'b0;
    end else begin
      light_sleep <= light_sleep_pin || control_cfg[adh_pkg::ADH_CW_LIGHT];
      deep_sleep <= control_cfg[adh_pkg::ADH_CW_DEEP];
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < adh_pkg::ADH_PAIRS; gp++) begin : g_pair
      adh_pair_seq u_seq (
        .clk(clk),
        .dev_rst(dev_rst),
        .conv_rise(conv_rise),
        .conv_fall(conv_fall),
        .sample_n(pair_sample_n[gp]),
        .track(seq_track[gp]),
        .latch_req(seq_latch[gp])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      pair_track <= 3'h7;
    end else begin
      pair_track <= seq_track;
    end
  end
  // A pair latches when it asks, or when a read in progress ends; pairs asking together take later conversion-clock falls.
  assign want = pending | seq_latch;
  assign latch_pair = want[0] ? 2'h0 : (want[1] ? 2'h1 : 2'h2);
  assign latch_due = (seq_latch != 3'h0) || conv_fall || late;
  assign do_latch = (want != 3'h0) && !rd_busy && latch_due;
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      pending <= 3'h0;
      late <= 1'b0;
    end else if (do_latch) begin
      pending <= want & ~(3'h1 << latch_pair);
      late <= 1'b0;
    end else begin
      pending <= want;
      late <= late || (latch_due && rd_busy && (want != 3'h0));
    end
  end
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      eoc_n <= 1'b1;
    end else if (do_latch) begin
      eoc_n <= 1'b0;
    end else if (conv_rise || conv_fall) begin
      eoc_n <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
        result[i] <= 16'h0000;
      end
      result_valid <= 6'h00;
    end else begin
      for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
        if (do_latch && (i / 2 == int'(latch_pair))) begin
          result[i] <= conv_result[i];
          result_valid[i] <= 1'b1;
        end else if (chan_done && sel_q == adh_pkg::ADH_SEL_CYCLE && i == int'(cyc_ptr)) begin
          result_valid[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    int drop, src, cnt, base;
    drop = 0;
    src = 0;
    cnt = int'(fifo_cnt);
    base = 0;
    next_fifo_cnt = fifo_cnt;
    for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
      next_fifo_data[i] = fifo_data[i];
      next_fifo_addr[i] = fifo_addr[i];
    end
    if (do_latch) begin
      base = 2 * int'(latch_pair);
      drop = (cnt > 4) ? cnt - 4 : 0;
      for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
        src = i + drop;
        if (src < cnt) begin
          next_fifo_data[i] = fifo_data[src];
          next_fifo_addr[i] = fifo_addr[src];
        end else if (src == cnt) begin
          next_fifo_data[i] = conv_result[base];
          next_fifo_addr[i] = 3'(base);
        end else if (src == cnt + 1) begin
          next_fifo_data[i] = conv_result[base + 1];
          next_fifo_addr[i] = 3'(base + 1);
        end
      end
      next_fifo_cnt = 3'(cnt + 2 - drop);
    end else if (chan_done && sel_q == adh_pkg::ADH_SEL_FIFO && fifo_cnt != 3'h0) begin
      for (int i = 0; i < adh_pkg::ADH_CHANNELS - 1; i++) begin
        next_fifo_data[i] = fifo_data[i + 1];
        next_fifo_addr[i] = fifo_addr[i + 1];
      end
      next_fifo_cnt = fifo_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
        fifo_data[i] <= 16'h0000;
        fifo_addr[i] <= 3'h0;
      end
      fifo_cnt <= 3'h0;
    end else begin
      for (int i = 0; i < adh_pkg::ADH_CHANNELS; i++) begin
        fifo_data[i] <= next_fifo_data[i];
        fifo_addr[i] <= next_fifo_addr[i];
      end
      fifo_cnt <= next_fifo_cnt;
    end
  end

  assign seq_mode = is_seq(sel_q);
  assign last_phase = {1'b0, byte_mode} + {1'b0, seq_mode && tag_on};
  assign chan_done = rd_end && (phase == last_phase);

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      sel_q <= 3'h0;
      phase <= 2'h0;
      cyc_ptr <= 3'h0;
    end else begin
      if (rd_start) begin
        sel_q <= sel_now;
      end
      if (chan_done) begin
        phase <= 2'h0;
        if (sel_q == adh_pkg::ADH_SEL_CYCLE) begin
          cyc_ptr <= (cyc_ptr == adh_pkg::ADH_PTR_LAST) ? 3'h0 : cyc_ptr + 3'h1;
        end
      end else if (rd_end && !(sel_q == adh_pkg::ADH_SEL_FIFO && fifo_cnt == 3'h0)) begin
        phase <= phase + 2'h1;
      end
    end
  end

  // The selector is taken at the start of each read and held while it lasts.
  always_comb begin
    logic [2:0] sel;
    logic [15:0] raw;
    logic [15:0] word;
    logic [2:0] addr;
    logic valid;
    logic [1:0] k;
    logic tag_read;
    sel = rd_start ? sel_now : sel_q;
    raw = 16'h0000;
    addr = 3'h0;
    valid = 1'b0;
    if (sel == adh_pkg::ADH_SEL_FIFO) begin
      if (fifo_cnt != 3'h0) begin
        raw = fifo_data[0];
        addr = fifo_addr[0];
        valid = 1'b1;
      end
    end else if (sel == adh_pkg::ADH_SEL_CYCLE) begin
      raw = result[cyc_ptr];
      addr = cyc_ptr;
      valid = result_valid[cyc_ptr];
    end else begin
      raw = result[sel];
      addr = sel;
      valid = result_valid[sel];
    end
    word = control_cfg[adh_pkg::ADH_CW_INV] ? {~raw[15], raw[14:0]} : raw;
    tag_read = is_seq(sel) && tag_on && (phase == 2'h0);
    k = (is_seq(sel) && tag_on) ? phase - 2'h1 : phase;
    if (tag_read) begin
      next_data = byte_mode ? both_lanes({valid, addr, word[3:0]})
                            : {adh_pkg::ADH_TAG_PREFIX, valid, addr};
    end else if (byte_mode) begin
      next_data = (k == 2'h0) ? both_lanes(word[7:0]) : both_lanes(word[15:8]);
    end else begin
      next_data = word;
    end
    if (sel == adh_pkg::ADH_SEL_FIFO && fifo_cnt == 3'h0) begin
      next_data = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      data_pins_out <= 16'h0000;
      data_pins_oe <= 1'b0;
    end else begin
      data_pins_oe <= rd_act;
      data_pins_out <= rd_act ? next_data : 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      first_channel_next <= 1'b0;
    end else if (sel_now == adh_pkg::ADH_SEL_FIFO) begin
      first_channel_next <= (fifo_cnt != 3'h0) && (fifo_addr[0] == 3'h0);
    end else if (sel_now == adh_pkg::ADH_SEL_CYCLE) begin
      first_channel_next <= (cyc_ptr == 3'h0);
    end else begin
      first_channel_next <= (sel_now == 3'h0);
    end
  end
endmodule // adh_host_port
`default_nettype wire

// ===== sim/adh_host_port_props.sv
/*
  Checker for the converter host port, bound to its top-level ports.
  Assumes conv_clk runs at most at clk/4 and each bus write is low for one edge.
*/
`timescale 1ns/10ps
`default_nettype none
module adh_host_port_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic light_sleep_pin,
  input wire logic data_pins_oe,
  input wire logic eoc_n,
  input wire logic first_channel_next,
  input wire logic [2:0] pair_track,
  input wire logic light_sleep,
  input wire logic deep_sleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_oe_cause: assert property (data_pins_oe |-> $past(!cs_n && !rd_n))
    else $error("data pins driven without a read");
  a_oe_follow: assert property ((!cs_n && !rd_n && reset_pin_n) |=> data_pins_oe)
    else $error("read strobe not answered");
  a_track_min: assert property ($fell(pair_track[0]) |-> !pair_track[0] [*8])
    else $error("pair A tracking resumed too early");
  a_track_eoc: assert property ($rose(pair_track[0]) |-> ##[1:6] !eoc_n)
    else $error("no latch after pair A finished");
  a_eoc_width: assert property ($fell(eoc_n) |-> !eoc_n [*3] ##[1:5] eoc_n)
    else $error("end of conversion pulse width wrong");
  a_deep_cause: assert property ($rose(deep_sleep) |-> $past(!cs_n && !wr_n, 2))
    else $error("deep sleep entered without a write");
  a_light_pin: assert property ((light_sleep_pin && reset_pin_n) [*3] |-> light_sleep)
    else $error("light sleep pin ignored");
  a_reset_vals: assert property (disable iff (1'b0) sys_rst |=>
    (eoc_n && pair_track == 3'h7 && !first_channel_next && !data_pins_oe))
    else $error("reset values wrong");
endmodule // adh_host_port_props

bind adh_host_port adh_host_port_props u_props (.clk, .sys_rst, .reset_pin_n, .cs_n, .rd_n,
  .wr_n, .light_sleep_pin, .data_pins_oe, .eoc_n, .first_channel_next, .pair_track,
  .light_sleep, .deep_sleep);
`default_nettype wire

// ===== sim/adh_host_bfm.sv
/*
  Host processor model: control writes, reads and hold strobes.
  Assumes the bench calls one task at a time; all drives land at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module adh_host_bfm (
  input wire logic clk,
  input wire logic [15:0] data_pins_out,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] data_pins_in,
  output logic pair_a_sample_n,
  output logic pair_b_sample_n,
  output logic pair_c_sample_n
);
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    {pair_a_sample_n, pair_b_sample_n, pair_c_sample_n} = 3'h7;
    data_pins_in = 16'h0000;
  end
  task automatic wr(input logic [7:0] b);
    @(negedge clk);
    data_pins_in = {8'h00, b};
    {cs_n, wr_n} = 2'h0;
    @(negedge clk);
    {cs_n, wr_n} = 2'h3;
    // A released bus must not keep showing the last word.
    data_pins_in = ~data_pins_in;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(output logic [15:0] d);
    @(negedge clk);
    {cs_n, rd_n} = 2'h0;
    repeat (6) @(negedge clk);
    d = data_pins_out;
    {cs_n, rd_n} = 2'h3;
    repeat (2) @(negedge clk);
  endtask
  // strobe pulse; spacing between pulses is the caller's duty
  task automatic hold(input logic [2:0] m);
    @(negedge clk);
    {pair_c_sample_n, pair_b_sample_n, pair_a_sample_n} = ~m;
    repeat (30) @(negedge clk);
    {pair_c_sample_n, pair_b_sample_n, pair_a_sample_n} = 3'h7;
  endtask
endmodule // adh_host_bfm
`default_nettype wire

// ===== sim/testbench.sv
/*
  Self-checking bench for the converter host port.
  Assumes the host model drives the bus; the bench drives pins and results.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, sys_rst, conv_clk, reset_pin_n, cs_n, rd_n, wr_n;
  logic pair_a_sample_n, pair_b_sample_n, pair_c_sample_n;
  logic read_sel0, read_sel1, read_sel2, light_sleep_pin, tag_enable_pin, byte_mode;
  logic [15:0] data_pins_in, data_pins_out, d;
  logic [15:0] res [6];
  logic data_pins_oe, eoc_n, first_channel_next, light_sleep, deep_sleep;
  logic [2:0] pair_track;
  int failures, check_count, n;

  adh_host_port u_dut (.clk, .sys_rst, .conv_clk, .reset_pin_n, .pair_a_sample_n,
    .pair_b_sample_n, .pair_c_sample_n, .read_sel0, .read_sel1, .read_sel2,
    .light_sleep_pin, .tag_enable_pin, .byte_mode, .cs_n, .rd_n, .wr_n, .data_pins_in,
    .conv_result(res), .data_pins_out, .data_pins_oe, .eoc_n, .first_channel_next,
    .pair_track, .light_sleep, .deep_sleep);
  adh_host_bfm u_host (.clk, .data_pins_out, .cs_n, .rd_n, .wr_n, .data_pins_in,
    .pair_a_sample_n, .pair_b_sample_n, .pair_c_sample_n);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    conv_clk = 1'b0;
    forever #40 conv_clk = ~conv_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // the window spans a full acquisition plus conversion cycle
  task automatic conv_wait(output int c);
    logic p;
    c = 0;
    p = 1'b1;
    repeat (260) begin
      @(negedge clk);
      if (p && !eoc_n) c++;
      p = eoc_n;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_direct;
    fork
      conv_wait(n);
      begin
        u_host.hold(3'h1);
        chk("track", 16'h0006, {13'h0, pair_track});
        u_host.hold(3'h1);
      end
    join
    chk("eoc count", 16'h0001, 16'(n));
    chk("track", 16'h0007, {13'h0, pair_track});
    u_host.rd(d);
    chk("A0", res[0], d);
    read_sel0 = 1'b1;
    u_host.rd(d);
    chk("A1", res[1], d);
    byte_mode = 1'b1;
    u_host.rd(d);
    chk("A1 low", {2{res[1][7:0]}}, d);
    u_host.rd(d);
    chk("A1 high", {2{res[1][15:8]}}, d);
    byte_mode = 1'b0;
    read_sel0 = 1'b0;
    $display("test direct done");
  endtask

  task automatic t_soft;
    u_host.wr(8'h07);
    u_host.rd(d);
    chk("cleared", 16'h0000, d);
    fork
      conv_wait(n);
      begin
        u_host.wr(8'h08);
        repeat (12) @(negedge clk);
        chk("track", 16'h0000, {13'h0, pair_track});
      end
    join
    chk("eoc count", 16'h0003, 16'(n));
    u_host.wr(8'h0F);
    u_host.wr(8'h96);
    chk("first", 16'h0001, {15'h0, first_channel_next});
    for (int i = 0; i < 6; i++) begin
      u_host.rd(d);
      chk("cycle", res[i] ^ 16'h8000, d);
    end
    $display("test soft done");
  endtask

  task automatic t_fifo;
    logic [15:0] e [5];
    e = '{16'h800A, res[2], 16'h800B, res[3], 16'h0000};
    u_host.wr(8'h07);
    u_host.wr(8'h87);
    tag_enable_pin = 1'b1;
    u_host.rd(d);
    chk("empty", 16'h0000, d);
    fork
      conv_wait(n);
      u_host.hold(3'h2);
    join
    for (int i = 0; i < 5; i++) begin
      u_host.rd(d);
      chk("fifo", e[i], d);
    end
    tag_enable_pin = 1'b0;
    u_host.wr(8'h07);
    $display("test fifo done");
  endtask

  task automatic t_sleep;
    light_sleep_pin = 1'b1;
    repeat (3) @(negedge clk);
    chk("light", 16'h0001, {15'h0, light_sleep});
    light_sleep_pin = 1'b0;
    u_host.wr(8'hA0);
    chk("sleeps", 16'h0001, {14'h0, light_sleep, deep_sleep});
    u_host.wr(8'h80);
    chk("deep off", 16'h0000, {15'h0, deep_sleep});
    $display("test sleep done");
  endtask

  task automatic t_pins;
    for (int i = 0; i < 6; i++) res[i] = 16'h1357 + 16'h2222 * 16'(i);
    fork
      conv_wait(n);
      u_host.hold(3'h7);
    join
    chk("eoc count", 16'h0003, 16'(n));
    {read_sel2, read_sel1, read_sel0} = 3'h5;
    u_host.rd(d);
    chk("C1", res[5], d);
    {read_sel2, read_sel1, read_sel0} = 3'h2;
    u_host.rd(d);
    chk("B0", res[2], d);
    chk("first", 16'h0000, {15'h0, first_channel_next});
    reset_pin_n = 1'b0;
    @(negedge clk);
    reset_pin_n = 1'b1;
    u_host.rd(d);
    chk("pin reset", 16'h0000, d);
    {read_sel2, read_sel1, read_sel0} = 3'h0;
    $display("test pins done");
  endtask

  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    failures = 0;
    check_count = 0;
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    {read_sel2, read_sel1, read_sel0} = 3'h0;
    {light_sleep_pin, tag_enable_pin, byte_mode} = 3'h0;
    for (int i = 0; i < 6; i++) res[i] = 16'hC0A5 + 16'h0111 * 16'(i);
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("idle track", 16'h0007, {13'h0, pair_track});
    t_direct();
    t_soft();
    t_fifo();
    t_sleep();
    t_pins();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
